// >>> shared/trc_pkg.sv
package trc_pkg;
  // Control byte layout.
  localparam int CTL_EN_BIT        = 7;
  localparam int CTL_WR_BIT        = 6;
  localparam int CTL_ADDR_MSB      = 5;
  localparam int ADDR_W            = 6;
  localparam int DATA_W            = 16;

  // Register numbers.
  localparam logic [5:0] REG_FIRMWARE_VERSION    = 6'h09;
  localparam logic [5:0] REG_UNLOCK_CODE_WORD    = 6'h1F;
  localparam logic [5:0] REG_FEATURE_CONFIG      = 6'h20;
  localparam logic [5:0] REG_INPUT_USER_OFFSET   = 6'h21;
  localparam logic [5:0] REG_INPUT_USER_GAIN     = 6'h22;
  localparam logic [5:0] REG_OUTPUT_USER_DEFAULT = 6'h23;
  localparam logic [5:0] REG_OUTPUT_USER_OFFSET  = 6'h24;
  localparam logic [5:0] REG_OUTPUT_USER_GAIN    = 6'h25;

  // Unlock value and reset values.
  localparam logic [15:0] UNLOCK_VALUE           = 16'h1235;
  localparam logic [15:0] CODE_WORD_RST          = 16'h0000;
  localparam logic [15:0] FEATURE_RST            = 16'h0404;
  localparam logic [15:0] OFFSET_RST             = 16'h0000;
  localparam logic [15:0] GAIN_RST               = 16'h0100;
  localparam logic [15:0] USER_DEFAULT_RST       = 16'h0000;
  // Arbitrary firmware identity value.
  localparam logic [15:0] FW_VERSION_DEFAULT     = 16'h3030;

  // Feature register fields.
  localparam int FEAT_IN_USER_SCALING_EN         = 0;
  localparam int FEAT_IN_STATUS_LOW_BITS_EN      = 3;
  localparam int FEAT_OUT_USER_SCALING_EN        = 8;
  localparam int FEAT_OUT_STATUS_LOW_BITS_EN     = 11;
  localparam int FEAT_USER_DEFAULT_LEVEL_EN      = 12;

  // Status-low-bits input format and user scaling format.
  localparam int STAT_BITS                       = 3;
  localparam int GAIN_FRAC                       = 8;
  localparam logic signed [15:0] FULL_SCALE_POS  = 16'sh7FFF;
  localparam logic signed [15:0] FULL_SCALE_NEG  = -16'sh7FFF;

  // Controller sequencer states.
  typedef enum logic [2:0] {
    TRC_IDLE = 3'b001,
    TRC_REQ  = 3'b010,
    TRC_WAIT = 3'b100
  } trc_host_state_t;
endpackage : trc_pkg

// >>> shared/trc_if.sv
`timescale 1ns/1ps
interface trc_if;
  logic [7:0]  control_byte;
  logic [15:0] controller_data_word;
  logic        exchange;
  logic [7:0]  status_byte;
  logic [15:0] terminal_data_word;

  modport terminal (input control_byte, input controller_data_word, input exchange,
                    output status_byte, output terminal_data_word);
  modport controller (output control_byte, output controller_data_word, output exchange,
                      input status_byte, input terminal_data_word);
endinterface : trc_if

// >>> verilog/trc_terminal.sv
`timescale 1ns/1ps
// Summary of operation
// - Alternative format puts value in bits 15..3.
// - Overflow bit 0 outside range; bits 1,2 zero.
// - Controller programs user scaling for standard format.
// - Input offset defaults 0, applied when enabled.
// - Input gain defaults 256, unity at 2^-8.
// - User default register sets output default level.
// - Output offset 0, gain 256, when enabled.
// - Control bit 7 selects register communication.
// - Control bit 6: zero read, one write.
// - Control bits 5..0 hold register number.
// - Read ignores controller data word.
// - Write data in controller word, high first.
// - Read echoes control byte and returns register.
// - Write echo clears bit 6; data invalid.
// - Protected registers reject writes except code word.
// - 0x1235 unlocks; other value relocks.
// - Reading code word returns stored value.
// - Register 9 holds two ASCII firmware characters.
// - New settings act only after restart.
// - Feature register is number 32, unlocked write.
// - Feature bit 3 selects status-low-bits input.
// - Feature bit 12 activates user default level.
// - Restart clears code word, protection active.
module trc_terminal #(
  parameter logic [15:0] FW_VERSION = trc_pkg::FW_VERSION_DEFAULT
) (
  // Clock and reset.
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // Link to the controller.
  trc_if.terminal                            link,
  // Analog side.
  input  wire logic signed [trc_pkg::DATA_W-1:0] adc_value_i,
  input  wire logic                          adc_over_range_i,
  output logic signed [trc_pkg::DATA_W-1:0]  dac_value_o,
  output logic                               dac_use_default_o,
  output logic signed [trc_pkg::DATA_W-1:0]  dac_default_o
);
  import trc_pkg::*;

  typedef struct packed {
    logic [15:0] code_word;
    logic [15:0] feature;
    logic [15:0] in_offset;
    logic [15:0] in_gain;
    logic [15:0] out_default;
    logic [15:0] out_offset;
    logic [15:0] out_gain;
    logic [15:0] active_feature;
    logic [15:0] active_in_offset;
    logic [15:0] active_in_gain;
    logic [15:0] active_out_default;
    logic [15:0] active_out_offset;
    logic [15:0] active_out_gain;
    logic        load;
    logic [7:0]  status;
    logic [15:0] data;
    logic [15:0] dac;
  } trc_term_state_t;

  // Power-up contents; the settings fields keep them until written, across any restart.
  localparam trc_term_state_t POWER_UP = '{code_word: CODE_WORD_RST, feature: FEATURE_RST, in_offset: OFFSET_RST,
    in_gain: GAIN_RST, out_default: USER_DEFAULT_RST, out_offset: OFFSET_RST, out_gain: GAIN_RST,
    active_feature: FEATURE_RST, active_in_offset: OFFSET_RST, active_in_gain: GAIN_RST,
    active_out_default: USER_DEFAULT_RST, active_out_offset: OFFSET_RST, active_out_gain: GAIN_RST,
    load: 1'b0, status: 8'h00, data: 16'h0000, dac: 16'h0000};

  trc_term_state_t s_q = POWER_UP;
  trc_term_state_t s_d;

  function automatic logic signed [15:0] trc_scale(input logic signed [15:0] v, input logic [15:0] off,
                                                   input logic [15:0] gain);
    logic signed [33:0] p;
    logic signed [33:0] r;
    p = 34'(v) * $signed({1'b0, gain});
    r = (p >>> GAIN_FRAC) + 34'($signed(off));
    if (r > 34'(FULL_SCALE_POS)) begin
      trc_scale = FULL_SCALE_POS;
    end else if (r < 34'(FULL_SCALE_NEG)) begin
      trc_scale = FULL_SCALE_NEG;
    end else begin
      trc_scale = r[15:0];
    end
  endfunction : trc_scale

  logic [5:0]  addr;
  logic        reg_mode;
  logic        wr;
  logic        unlocked;
  logic [15:0] rd_word;
  logic signed [15:0] in_scaled;
  logic signed [15:0] out_val;

  assign reg_mode = link.control_byte[CTL_EN_BIT];
  assign wr       = link.control_byte[CTL_WR_BIT];
  assign addr     = link.control_byte[CTL_ADDR_MSB:0];
  assign unlocked = (s_q.code_word == UNLOCK_VALUE);

  always_comb begin
    case (addr)
      REG_FIRMWARE_VERSION:    rd_word = FW_VERSION;
      REG_UNLOCK_CODE_WORD:    rd_word = s_q.code_word;
      REG_FEATURE_CONFIG:      rd_word = s_q.feature;
      REG_INPUT_USER_OFFSET:   rd_word = s_q.in_offset;
      REG_INPUT_USER_GAIN:     rd_word = s_q.in_gain;
      REG_OUTPUT_USER_DEFAULT: rd_word = s_q.out_default;
      REG_OUTPUT_USER_OFFSET:  rd_word = s_q.out_offset;
      REG_OUTPUT_USER_GAIN:    rd_word = s_q.out_gain;
      default:                 rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    // Terminal behaviour uses the snapshot taken at restart, not the live registers.
    if (s_q.active_feature[FEAT_IN_USER_SCALING_EN]) begin
      in_scaled = trc_scale(adc_value_i, s_q.active_in_offset, s_q.active_in_gain);
    end else begin
      in_scaled = adc_value_i;
    end
    if (s_q.active_feature[FEAT_OUT_USER_SCALING_EN]) begin
      out_val = trc_scale($signed(link.controller_data_word), s_q.active_out_offset,
                          s_q.active_out_gain);
    end else begin
      out_val = $signed(link.controller_data_word);
    end
  end

  always_comb begin
    s_d = s_q;
    // The first cycle after a restart copies the retained settings into the working snapshot.
    if (s_q.load) begin
      s_d.load               = 1'b0;
      s_d.active_feature     = s_q.feature;
      s_d.active_in_offset   = s_q.in_offset;
      s_d.active_in_gain     = s_q.in_gain;
      s_d.active_out_default = s_q.out_default;
      s_d.active_out_offset  = s_q.out_offset;
      s_d.active_out_gain    = s_q.out_gain;
    end
    if (link.exchange) begin
      if (reg_mode) begin
        if (wr) begin
          s_d.status = {link.control_byte[7], 1'b0, link.control_byte[5:0]};
          s_d.data   = 16'h0000;
          if (addr == REG_UNLOCK_CODE_WORD) begin
            s_d.code_word = link.controller_data_word;
          end else if (unlocked) begin
            case (addr)
              REG_FEATURE_CONFIG:      s_d.feature     = link.controller_data_word;
              REG_INPUT_USER_OFFSET:   s_d.in_offset   = link.controller_data_word;
              REG_INPUT_USER_GAIN:     s_d.in_gain     = link.controller_data_word;
              REG_OUTPUT_USER_DEFAULT: s_d.out_default = link.controller_data_word;
              REG_OUTPUT_USER_OFFSET:  s_d.out_offset  = link.controller_data_word;
              REG_OUTPUT_USER_GAIN:    s_d.out_gain    = link.controller_data_word;
              default:                 s_d.out_gain    = s_q.out_gain;
            endcase
          end
        end else begin
          s_d.status = link.control_byte;
          s_d.data   = rd_word;
        end
      end else begin
        s_d.status = link.control_byte;
        s_d.dac    = out_val;
        if (s_q.active_feature[FEAT_IN_STATUS_LOW_BITS_EN]) begin
          s_d.data = {in_scaled[15:STAT_BITS], 2'b00, adc_over_range_i};
        end else begin
          s_d.data = in_scaled;
        end
      end
    end
  end

  // The settings fields model retained memory, so a restart leaves them alone; it resets the code word, snapshot, status, data and dac fields and re-arms the load.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.code_word          <= CODE_WORD_RST;
      s_q.load               <= 1'b1;
      s_q.active_feature     <= FEATURE_RST;
      s_q.active_in_offset   <= OFFSET_RST;
      s_q.active_in_gain     <= GAIN_RST;
      s_q.active_out_default <= USER_DEFAULT_RST;
      s_q.active_out_offset  <= OFFSET_RST;
      s_q.active_out_gain    <= GAIN_RST;
      s_q.status             <= 8'h00;
      s_q.data               <= 16'h0000;
      s_q.dac                <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.status_byte        = s_q.status;
  assign link.terminal_data_word = s_q.data;
  assign dac_value_o             = s_q.dac;
  assign dac_use_default_o       = s_q.active_feature[FEAT_USER_DEFAULT_LEVEL_EN];
  assign dac_default_o           = s_q.active_out_default;
endmodule : trc_terminal

// >>> verilog/trc_controller.sv
`timescale 1ns/1ps
module trc_controller (
  // Clock and reset.
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  // User request.
  input  wire logic                     req_valid_i,
  input  wire logic                     req_reg_i,
  input  wire logic                     req_write_i,
  input  wire logic [5:0]               req_addr_i,
  input  wire logic [15:0]              req_wdata_i,
  output logic                          req_ready_o,
  // User answer.
  output logic                          rsp_valid_o,
  output logic [7:0]                    rsp_status_o,
  output logic [15:0]                   rsp_data_o,
  output logic                          rsp_data_valid_o,
  // Link to the terminal.
  trc_if.controller                     link
);
  import trc_pkg::*;

  typedef struct packed {
    trc_host_state_t st;
    logic [7:0]      ctl;
    logic [15:0]     wdata;
    logic            rsp_valid;
    logic [7:0]      rsp_status;
    logic [15:0]     rsp_data;
    logic            rsp_data_valid;
  } trc_host_q_t;

  trc_host_q_t s_q;
  trc_host_q_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    case (s_q.st)
      TRC_IDLE: begin
        if (req_valid_i) begin
          s_d.ctl   = {req_reg_i, req_reg_i & req_write_i, req_addr_i};
          s_d.wdata = req_wdata_i;
          s_d.st    = TRC_REQ;
        end
      end
      TRC_REQ: s_d.st = TRC_WAIT;
      TRC_WAIT: begin
        s_d.st             = TRC_IDLE;
        s_d.rsp_valid      = 1'b1;
        s_d.rsp_status     = link.status_byte;
        s_d.rsp_data       = link.terminal_data_word;
        s_d.rsp_data_valid = !(s_q.ctl[CTL_EN_BIT] & s_q.ctl[CTL_WR_BIT]);
      end
      default: s_d.st = TRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{st: TRC_IDLE, ctl: 8'h00, wdata: 16'h0000, rsp_valid: 1'b0,
               rsp_status: 8'h00, rsp_data: 16'h0000, rsp_data_valid: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready_o               = (s_q.st == TRC_IDLE);
  assign link.control_byte         = s_q.ctl;
  assign link.controller_data_word = s_q.wdata;
  assign link.exchange             = (s_q.st == TRC_REQ);
  assign rsp_valid_o               = s_q.rsp_valid;
  assign rsp_status_o              = s_q.rsp_status;
  assign rsp_data_o                = s_q.rsp_data;
  assign rsp_data_valid_o          = s_q.rsp_data_valid;
endmodule : trc_controller

// >>> testbench/trc_link_sva.sv
`timescale 1ns/1ps
module trc_link_sva
  import trc_pkg::*;
#(
  parameter logic [15:0] FW_VERSION = FW_VERSION_DEFAULT
) (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Link signals.
  input wire logic [7:0]  control_byte,
  input wire logic [15:0] controller_data_word,
  input wire logic        exchange,
  input wire logic [7:0]  status_byte,
  input wire logic [15:0] terminal_data_word
);
  logic [15:0] code_q;
  logic [15:0] user_q [6] = '{FEATURE_RST, OFFSET_RST, GAIN_RST, USER_DEFAULT_RST, OFFSET_RST, GAIN_RST};
  logic [15:0] rd_val;
  logic [2:0]  idx;
  logic        wr_ex;

  assign wr_ex  = exchange && control_byte[7:6] == 2'b11;
  assign idx    = control_byte[2:0];
  assign rd_val = (idx < 3'd6) ? user_q[idx] : 16'h0000;

  // Shadow copy of what the terminal should store, so readback can be judged.
  // Only the code word is cleared by a restart; the settings are retained.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_q <= CODE_WORD_RST;
    end else if (wr_ex && control_byte[5:0] == REG_UNLOCK_CODE_WORD) begin
      code_q <= controller_data_word;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_n_i && wr_ex && code_q == UNLOCK_VALUE && control_byte[5:3] == 3'b100 && idx < 3'd6) begin
      user_q[idx] <= controller_data_word;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_read(logic [5:0] a);
    exchange && control_byte == {2'b10, a};
  endsequence

  AST_READ_ECHO: assert property (exchange && control_byte[7:6] == 2'b10 |=>
    status_byte == $past(control_byte)) else $error("read receipt differs from control byte");
  AST_WRITE_ECHO: assert property (wr_ex |=> status_byte == ($past(control_byte) & 8'hBF))
    else $error("write receipt wrong");
  AST_PROC_ECHO: assert property (exchange && !control_byte[7] |=> status_byte == $past(control_byte))
    else $error("process data receipt wrong");
  AST_FW_READ: assert property (s_read(REG_FIRMWARE_VERSION) |=> terminal_data_word == FW_VERSION)
    else $error("firmware version readback wrong");
  AST_CODE_READ: assert property (s_read(REG_UNLOCK_CODE_WORD) |=> terminal_data_word == code_q)
    else $error("code word readback wrong");
  AST_USER_READ: assert property (exchange && control_byte[7:3] == 5'b10100 && idx < 3'd6 |=>
    terminal_data_word == $past(rd_val)) else $error("user register readback wrong");
  AST_STATUS_HOLD: assert property (!exchange |=> $stable(status_byte) && $stable(terminal_data_word))
    else $error("answer changed without exchange");
  AST_EXCH_SPACING: assert property (exchange |=> !exchange [*2])
    else $error("exchanges too close");
endmodule : trc_link_sva

// >>> testbench/terminal_register_channel_test.sv
`timescale 1ns/1ps
module terminal_register_channel_test;
  import trc_pkg::*;
  // Arbitrary identity value.
  localparam logic [15:0] FW_TEST = 16'h4142;
  logic               clk_i            = 1'b0;
  logic               rst_n_i          = 1'b0;
  logic               req_valid_i      = 1'b0;
  logic               req_reg_i        = 1'b0;
  logic               req_write_i      = 1'b0;
  logic [5:0]         req_addr_i       = 6'h00;
  logic [15:0]        req_wdata_i      = 16'h0000;
  logic signed [15:0] adc_value_i      = 16'sh1230;
  logic               adc_over_range_i = 1'b0;
  logic               req_ready_o, rsp_valid_o, rsp_data_valid_o, dac_use_default_o;
  logic [7:0]         rsp_status_o;
  logic [15:0]        rsp_data_o, dac_value_o, dac_default_o;
  int                 num_errors = 0;
  int                 n_checks   = 0;

  trc_if link_if ();
  always #20 clk_i = ~clk_i;

  trc_terminal #(.FW_VERSION(FW_TEST)) trc_terminal_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if),
    .adc_value_i(adc_value_i), .adc_over_range_i(adc_over_range_i), .dac_value_o(dac_value_o),
    .dac_use_default_o(dac_use_default_o), .dac_default_o(dac_default_o));
  trc_controller trc_controller_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_reg_i(req_reg_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_status_o(rsp_status_o),
    .rsp_data_o(rsp_data_o), .rsp_data_valid_o(rsp_data_valid_o), .link(link_if));
  trc_link_sva #(.FW_VERSION(FW_TEST)) trc_link_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .control_byte(link_if.control_byte), .controller_data_word(link_if.controller_data_word),
    .exchange(link_if.exchange), .status_byte(link_if.status_byte),
    .terminal_data_word(link_if.terminal_data_word));

  task automatic end_of_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask : chk

  // One request through the controller; waits for its answer under a bound.
  task automatic xfer(input logic r, input logic w, input logic [5:0] a, input logic [15:0] d);
    int i;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_reg_i   <= r;
    req_write_i <= w;
    req_addr_i  <= a;
    req_wdata_i <= d;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    for (i = 0; i < 10 && rsp_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (i == 10) begin
      chk("response timeout", 16'h0001, 16'h0000);
      end_of_test();
    end
    chk("ready after answer", 16'h0001, {15'h0000, req_ready_o});
    if (r) begin
      chk("control byte", {8'h00, 1'b1, w, a}, {8'h00, link_if.control_byte});
      chk("receipt", {8'h00, 2'b10, a}, {8'h00, rsp_status_o});
      chk("data valid", {15'h0000, ~w}, {15'h0000, rsp_data_valid_o});
    end
  endtask : xfer

  // The data word sent with a read is junk on purpose; it must be ignored.
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    xfer(1'b1, 1'b0, a, 16'hA5A5);
    chk(what, exp, rsp_data_o);
  endtask : rd

  task automatic reset_values;
    logic [15:0] exp [6] = '{FEATURE_RST, OFFSET_RST, GAIN_RST, USER_DEFAULT_RST, OFFSET_RST, GAIN_RST};
    for (int k = 0; k < 6; k++) begin
      rd(REG_FEATURE_CONFIG + 6'(k), exp[k], "user register reset");
    end
    rd(REG_UNLOCK_CODE_WORD, CODE_WORD_RST, "code word after start");
    rd(REG_FIRMWARE_VERSION, FW_TEST, "firmware version");
    rd(6'h3F, 16'h0000, "unmapped register");
  endtask : reset_values

  task automatic locked_writes;
    xfer(1'b1, 1'b1, REG_INPUT_USER_OFFSET, 16'h0055);
    rd(REG_INPUT_USER_OFFSET, OFFSET_RST, "protected offset");
    xfer(1'b0, 1'b1, REG_UNLOCK_CODE_WORD, UNLOCK_VALUE);
    chk("process input word", 16'h1230, rsp_data_o);
    chk("process output word", UNLOCK_VALUE, dac_value_o);
    rd(REG_UNLOCK_CODE_WORD, CODE_WORD_RST, "code word after process data");
  endtask : locked_writes

  task automatic unlocked_writes;
    xfer(1'b1, 1'b1, REG_UNLOCK_CODE_WORD, UNLOCK_VALUE);
    rd(REG_UNLOCK_CODE_WORD, UNLOCK_VALUE, "code word");
    xfer(1'b1, 1'b1, REG_FEATURE_CONFIG, 16'h1008);
    rd(REG_FEATURE_CONFIG, 16'h1008, "feature register");
    xfer(1'b1, 1'b1, REG_OUTPUT_USER_DEFAULT, 16'h0321);
    rd(REG_OUTPUT_USER_DEFAULT, 16'h0321, "user default");
    chk("default level in use", {15'h0000, FEATURE_RST[FEAT_USER_DEFAULT_LEVEL_EN]},
        {15'h0000, dac_use_default_o});
    xfer(1'b1, 1'b1, REG_UNLOCK_CODE_WORD, 16'h1234);
    xfer(1'b1, 1'b1, REG_INPUT_USER_GAIN, 16'h0200);
    rd(REG_INPUT_USER_GAIN, GAIN_RST, "gain after relock");
  endtask : unlocked_writes

  // Restart of the terminal; the controller restarts with it.
  task automatic power_cycle;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask : power_cycle

  // Settings written before the restart (feature 0x1008, default 0x0321) act only now.
  task automatic restart;
    xfer(1'b1, 1'b1, REG_UNLOCK_CODE_WORD, UNLOCK_VALUE);
    power_cycle();
    rd(REG_UNLOCK_CODE_WORD, CODE_WORD_RST, "code word after restart");
    xfer(1'b1, 1'b1, REG_INPUT_USER_GAIN, 16'h0200);
    rd(REG_INPUT_USER_GAIN, GAIN_RST, "gain after restart");
    chk("default level in use after restart", 16'h0001, {15'h0000, dac_use_default_o});
    chk("default level", 16'h0321, dac_default_o);
    @(posedge clk_i);
    adc_value_i      <= 16'sh1237;
    adc_over_range_i <= 1'b1;
    xfer(1'b0, 1'b0, 6'h00, 16'h0000);
    chk("status format over range", 16'h1231, rsp_data_o);
  endtask : restart

  // The controller gets standard scaling only by programming the user scaling itself.
  task automatic scaled_values;
    xfer(1'b1, 1'b1, REG_UNLOCK_CODE_WORD, UNLOCK_VALUE);
    xfer(1'b1, 1'b1, REG_FEATURE_CONFIG, 16'h1109);
    xfer(1'b1, 1'b1, REG_INPUT_USER_OFFSET, 16'h0010);
    xfer(1'b1, 1'b1, REG_INPUT_USER_GAIN, 16'h0200);
    xfer(1'b1, 1'b1, REG_OUTPUT_USER_OFFSET, 16'h0008);
    xfer(1'b1, 1'b1, REG_OUTPUT_USER_GAIN, 16'h0080);
    rd(REG_INPUT_USER_GAIN, 16'h0200, "gain written");
    power_cycle();
    @(posedge clk_i);
    adc_value_i      <= 16'sh1000;
    adc_over_range_i <= 1'b0;
    xfer(1'b0, 1'b0, 6'h00, 16'h0400);
    // Input: 0x1000 times 2 plus 0x0010; output: 0x0400 times one half plus 0x0008.
    chk("scaled input in range", 16'h2010, rsp_data_o);
    chk("scaled output", 16'h0208, dac_value_o);
  endtask : scaled_values

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reset_values();
    locked_writes();
    unlocked_writes();
    restart();
    scaled_values();
    end_of_test();
  end
endmodule : terminal_register_channel_test
